// file: core/mtr_target.sv
// serial-bus target giving a host read access to the monitoring registers
`timescale 1ns/1ps
`default_nettype none
`include "mtr_map.svh"
// How it works
// - start seen as data falling while clock stays high
// - stop seen as data rising while clock high; transfer ends
// - address and data bytes shift most significant bit first
// - matching address gets acknowledge; target takes opposite role
// - write-only index pointer loads from first data byte of a write
// - later write bytes are not stored, they only bump the pointer
// - each read byte returns pointed register, then pointer increments
// - pointer is eight bits, clears at reset, sticks at its maximum
// - writes to unimplemented indexes change nothing, pointer still increments
// - reads of unimplemented indexes return zero, pointer still increments
// - address upper four bits fixed 0101, direction bit is the lsb
// - three low address bits come from the strap, eight addresses
// - readable: status, holdup, current, feed a, feed b, temperature
// - registers start zero, update after 300 ms, then every 100 ms together
// - status bits: enables, alarm, holdup, hotswap, output ok; 3 and 7 zero
module mtr_target #(
  parameter longint START_CYCLES  = `MTR_START_CYCLES,
  parameter longint UPDATE_CYCLES = `MTR_UPDATE_CYCLES,
  parameter int     FIFO_DEPTH    = 16
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  // serial bus pins
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  // address strap
  input  wire logic [2:0]          addr_strap,
  // measurement inputs
  input  wire mtr_pkg::mtr_byte_t  holdup_cap_voltage,
  input  wire mtr_pkg::mtr_byte_t  output_current,
  input  wire mtr_pkg::mtr_byte_t  feed_a_voltage,
  input  wire mtr_pkg::mtr_byte_t  feed_b_voltage,
  input  wire mtr_pkg::mtr_byte_t  avg_temperature,
  input  wire logic                feed_a_enable,
  input  wire logic                feed_b_enable,
  input  wire logic                primary_alarm,
  input  wire logic                holdup_switch,
  input  wire logic                hotswap_switch,
  input  wire logic                vout_above_uv,
  // sample handshake towards the register bank
  output logic                     sample_ready
);
  import mtr_pkg::*;

  // ==========================================================
  // pin synchronisers and edge detection
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [2:0] strap_sync0;
  logic [2:0] strap_sync1;
  logic       scl_d;
  logic       sda_d;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync    <= 2'b11;
      sda_sync    <= 2'b11;
      strap_sync0 <= 3'h0;
      strap_sync1 <= 3'h0;
      scl_d       <= 1'b1;
      sda_d       <= 1'b1;
    end else begin
      scl_sync    <= {scl_sync[0], scl_in};
      sda_sync    <= {sda_sync[0], sda_in};
      strap_sync0 <= addr_strap;
      strap_sync1 <= strap_sync0;
      scl_d       <= scl_sync[1];
      sda_d       <= sda_sync[1];
    end
  end

  assign scl_rise  = scl_sync[1] && !scl_d;
  assign scl_fall  = !scl_sync[1] && scl_d;
  assign start_det = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
  assign stop_det  = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

  // ==========================================================
  // measurement snapshots through the fifo
  logic [47:0] snap_in;
  logic [47:0] snap_out;
  logic        snap_valid;
  logic        tick;
  logic        busy;
  logic        started;
  logic        next_started;
  longint      timer;
  longint      next_timer;
  mtr_byte_t   bank [6];
  mtr_byte_t   next_bank [6];

  assign snap_in = {2'b00, vout_above_uv, hotswap_switch, holdup_switch, 1'b0,
                    primary_alarm, feed_b_enable, feed_a_enable, 1'b0} == 10'h0 ?
                   {holdup_cap_voltage, output_current, feed_a_voltage, feed_b_voltage,
                    avg_temperature, 8'h00} :
                   {holdup_cap_voltage, output_current, feed_a_voltage, feed_b_voltage,
                    avg_temperature, 1'b0, vout_above_uv, hotswap_switch, holdup_switch,
                    1'b0, primary_alarm, feed_b_enable, feed_a_enable};

  always_comb begin
    next_timer   = timer + 64'sd1;
    next_started = started;
    tick         = 1'b0;
    if (!started && timer >= START_CYCLES - 1) begin
      tick         = 1'b1;
      next_started = 1'b1;
      next_timer   = 64'sd0;
    end else if (started && timer >= UPDATE_CYCLES - 1) begin
      tick       = 1'b1;
      next_timer = 64'sd0;
    end
  end

  mtr_fifo #(
    .WIDTH (48),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (tick),
    .in_ready  (sample_ready),
    .in_data   (snap_in),
    .out_valid (snap_valid),
    .out_ready (!busy),
    .out_data  (snap_out)
  );

  // bank only reloads while idle or ignoring the bus so a read never sees a mix
  always_comb begin
    next_bank = bank;
    if (snap_valid && !busy) begin
      next_bank[0] = snap_out[7:0];
      next_bank[1] = snap_out[47:40];
      next_bank[2] = snap_out[39:32];
      next_bank[3] = snap_out[31:24];
      next_bank[4] = snap_out[23:16];
      next_bank[5] = snap_out[15:8];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer   <= 64'sd0;
      started <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        bank[i] <= 8'h00;
      end
    end else begin
      timer   <= next_timer;
      started <= next_started;
      bank    <= next_bank;
    end
  end

  function automatic mtr_byte_t reg_read(input mtr_byte_t idx);
    if (idx == `MTR_IDX_STATUS) begin
      reg_read = bank[0];
    end else if (idx == `MTR_IDX_HOLDUP) begin
      reg_read = bank[1];
    end else if (idx == `MTR_IDX_CURRENT) begin
      reg_read = bank[2];
    end else if (idx == `MTR_IDX_FEED_A) begin
      reg_read = bank[3];
    end else if (idx == `MTR_IDX_FEED_B) begin
      reg_read = bank[4];
    end else if (idx == `MTR_IDX_TEMP) begin
      reg_read = bank[5];
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  function automatic mtr_byte_t ptr_inc(input mtr_byte_t p);
    ptr_inc = (p == `MTR_PTR_MAX) ? p : p + 8'h01;
  endfunction

  // ==========================================================
  // bus state machine
  mtr_state_t state;
  mtr_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  mtr_byte_t  shreg;
  mtr_byte_t  next_shreg;
  mtr_byte_t  register_index_pointer;
  mtr_byte_t  next_ptr;
  logic       first_wr;
  logic       next_first_wr;
  logic       drive_low;
  logic       next_drive_low;
  logic       rd_mode;
  logic       next_rd_mode;
  logic       have_bits;
  logic       next_have_bits;
  mtr_byte_t  rd_byte;

  assign busy     = (state != MTR_IDLE) && (state != MTR_IGNORE);
  assign sda_out  = 1'b0;
  assign sda_oe_n = !drive_low;

  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_ptr       = register_index_pointer;
    next_first_wr  = first_wr;
    next_drive_low = drive_low;
    next_rd_mode   = rd_mode;
    next_have_bits = have_bits;
    rd_byte        = reg_read(register_index_pointer);
    if (start_det) begin
      next_state     = MTR_ADDR;
      next_bit_cnt   = 3'd0;
      next_drive_low = 1'b0;
      next_have_bits = 1'b0;
    end else if (stop_det) begin
      next_state     = MTR_IDLE;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        MTR_ADDR, MTR_WR_BYTE: begin
          if (scl_rise) begin
            next_shreg     = {shreg[6:0], sda_sync[1]};
            next_bit_cnt   = bit_cnt + 3'd1;
            next_have_bits = 1'b1;
          end else if (scl_fall && bit_cnt == 3'd0 && have_bits) begin
            next_have_bits = 1'b0;
            if (state == MTR_ADDR) begin
              if (shreg[7:1] == {`MTR_ADDR_FIXED, strap_sync1}) begin
                next_drive_low = 1'b1;
                next_rd_mode   = shreg[0];
                next_first_wr  = 1'b1;
                next_state     = MTR_ADDR_ACK;
              end else begin
                next_state = MTR_IGNORE;
              end
            end else begin
              if (first_wr) begin
                next_ptr = shreg;
              end else begin
                next_ptr = ptr_inc(register_index_pointer);
              end
              next_first_wr  = 1'b0;
              next_drive_low = 1'b1;
              next_state     = MTR_WR_ACK;
            end
          end
        end
        MTR_ADDR_ACK, MTR_WR_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = 3'd0;
            if (rd_mode) begin
              next_shreg     = rd_byte;
              next_ptr       = ptr_inc(register_index_pointer);
              next_drive_low = !rd_byte[7];
              next_state     = MTR_RD_BYTE;
            end else begin
              next_drive_low = 1'b0;
              next_state     = MTR_WR_BYTE;
            end
          end
        end
        MTR_RD_BYTE: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              next_drive_low = 1'b0;
              next_state     = MTR_RD_ACK;
            end else begin
              next_shreg     = {shreg[6:0], 1'b0};
              next_drive_low = !shreg[6];
            end
          end
        end
        MTR_RD_ACK: begin
          if (scl_rise) begin
            if (sda_sync[1]) begin
              next_state = MTR_IGNORE;
            end else begin
              next_state = MTR_ADDR_ACK;
            end
          end
        end
        MTR_IGNORE: begin
          next_drive_low = 1'b0;
        end
        default: begin
          next_state = MTR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state                  <= MTR_IDLE;
      bit_cnt                <= 3'd0;
      shreg                  <= 8'h00;
      register_index_pointer <= `MTR_PTR_RESET;
      first_wr               <= 1'b0;
      drive_low              <= 1'b0;
      rd_mode                <= 1'b0;
      have_bits              <= 1'b0;
    end else begin
      state                  <= next_state;
      bit_cnt                <= next_bit_cnt;
      shreg                  <= next_shreg;
      register_index_pointer <= next_ptr;
      first_wr               <= next_first_wr;
      drive_low              <= next_drive_low;
      rd_mode                <= next_rd_mode;
      have_bits              <= next_have_bits;
    end
  end
endmodule
`default_nettype wire

// file: core/mtr_map.svh
// register offsets, field positions, reset values and timing counts for the monitor target
`ifndef MTR_MAP_SVH
`define MTR_MAP_SVH
`define MTR_ADDR_FIXED      4'h5
`define MTR_IDX_STATUS      8'h1E
`define MTR_IDX_HOLDUP      8'h1F
`define MTR_IDX_CURRENT     8'h21
`define MTR_IDX_FEED_A      8'h22
`define MTR_IDX_FEED_B      8'h23
`define MTR_IDX_TEMP        8'h28
`define MTR_PTR_RESET       8'h00
`define MTR_PTR_MAX         8'hFF
`define MTR_ST_FEED_A_EN    0
`define MTR_ST_FEED_B_EN    1
`define MTR_ST_ALARM        2
`define MTR_ST_HOLDUP_SW    4
`define MTR_ST_HOTSWAP_SW   5
`define MTR_ST_VOUT_OK      6
`define MTR_CLK_MHZ         125
`define MTR_START_DELAY_MS  300
`define MTR_UPDATE_MS       100
`define MTR_START_CYCLES    (`MTR_START_DELAY_MS * 1000 * `MTR_CLK_MHZ)
`define MTR_UPDATE_CYCLES   (`MTR_UPDATE_MS * 1000 * `MTR_CLK_MHZ)
`endif

// file: core/mtr_pkg.sv
// types for the monitor target
package mtr_pkg;
  typedef enum logic [2:0] {
    MTR_IDLE,
    MTR_ADDR,
    MTR_ADDR_ACK,
    MTR_WR_BYTE,
    MTR_WR_ACK,
    MTR_RD_BYTE,
    MTR_RD_ACK,
    MTR_IGNORE
  } mtr_state_t;
  typedef logic [7:0] mtr_byte_t;
endpackage

// file: core/mtr_fifo.sv
// small fifo holding snapshot words on their way into the register bank
`timescale 1ns/1ps
`default_nettype none
module mtr_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;

  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign do_wr     = in_valid && !full;
  assign do_rd     = out_ready && !empty;

  always_comb begin
    next_wr_ptr = wr_ptr + (AW+1)'(do_wr);
    next_rd_ptr = rd_ptr + (AW+1)'(do_rd);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // read data from a register, refreshed to show the head word;
  // a word written into the slot that becomes the head passes straight through
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_data <= '0;
    end else if (do_wr && (wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0])) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[next_rd_ptr[AW-1:0]];
    end
  end
endmodule
`default_nettype wire

// file: verif/mtr_target_assertions.sv
// concurrent checks on the monitor target bus pins
`timescale 1ns/1ps
`default_nettype none
`include "mtr_map.svh"
module mtr_target_assertions (
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // bus pins and strap
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic [2:0] addr_strap
);
  // ==========
  // bus decode
  logic       sq;
  logic       dq;
  logic       first;
  logic       mis;
  logic [3:0] n;
  logic [6:0] sh;
  logic [3:0] low_cnt;
  wire logic  rise = scl_in && !sq;
  wire logic  strt = scl_in && sq && dq && !sda_in;
  wire logic  stp  = scl_in && sq && !dq && sda_in;
  wire logic  adr  = first && rise && n == 4'h7;
  wire logic  hit  = adr && sh == {`MTR_ADDR_FIXED, addr_strap};
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {sq, dq} <= 2'b11;
      {first, mis, n, sh} <= '0;
      low_cnt <= 4'h0;
    end else begin
      sq <= scl_in;
      dq <= sda_in;
      low_cnt <= sda_oe_n ? 4'h0 : low_cnt + {3'h0, rise};
      if (strt) begin
        {first, mis, n} <= {2'b10, 4'h0};
      end else if (rise) begin
        sh <= {sh[5:0], sda_in};
        n <= (n == 4'h8) ? 4'h0 : n + 4'h1;
        first <= first && n != 4'h8;
        mis <= mis || (adr && !hit);
      end
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_open_drain; sda_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data output not low");
  property p_reset_free; $fell(sys_rst) |-> sda_oe_n ##1 sda_oe_n; endproperty
  a_reset_free: assert property (p_reset_free) else $error("data driven after reset");
  property p_change_low; $changed(sda_oe_n) |-> !scl_in && !$past(scl_in); endproperty
  a_change_low: assert property (p_change_low) else $error("data changed with clock high");
  property p_start_free; strt |-> sda_oe_n; endproperty
  a_start_free: assert property (p_start_free) else $error("data driven at start");
  property p_stop_free; stp |=> sda_oe_n [*8]; endproperty
  a_stop_free: assert property (p_stop_free) else $error("data driven after stop");
  property p_ack_hold; $fell(sda_oe_n) |-> !sda_oe_n [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("drive shorter than a bit");
  property p_drive_bound; low_cnt <= 4'h9; endproperty
  a_drive_bound: assert property (p_drive_bound) else $error("drive held past byte");
  property p_mis_quiet; mis |-> sda_oe_n; endproperty
  a_mis_quiet: assert property (p_mis_quiet) else $error("driven for other address");
  property p_match_ack; hit |-> ##[1:24] !sda_oe_n; endproperty
  a_match_ack: assert property (p_match_ack) else $error("own address not acknowledged");
  c_match: cover property (hit);
  c_mismatch: cover property (adr && !hit);
  c_long_drive: cover property (low_cnt == 4'h9);
endmodule
`default_nettype wire

// file: verif/mtr_i2c_host.sv
// behavioural bus controller facing the monitor target
`timescale 1ns/1ps
`default_nettype none
module mtr_i2c_host (
  // clock
  input wire logic mclk,
  // bus lines
  input wire logic sda_wire,
  output var logic scl,
  output var logic sda
);
  // ==========
  // bus phases, a quarter bit each
  int slow = 0;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic q;
    repeat (4 + slow) @(posedge mclk);
  endtask
  task automatic start;
    sda <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda <= 1'b0;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic stop;
    sda <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda <= 1'b1;
    q;
  endtask
  // eight bits then the acknowledge bit; released data reads high
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r, output logic got);
    logic [8:0] w;
    for (int i = 8; i >= 0; i--) begin
      sda <= (i > 0) ? d[i-1] : ak;
      q;
      scl <= 1'b1;
      q;
      w[i] = sda_wire;
      q;
      scl <= 1'b0;
      q;
    end
    r = w[8:1];
    got = !w[0];
  endtask
endmodule
`default_nettype wire

// file: verif/test_mtr_target.sv
// self-checking bench for the monitor target
`timescale 1ns/1ps
`default_nettype none
`include "mtr_map.svh"
module test_mtr_target;
  import mtr_pkg::*;
  // ==========
  // signals
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [2:0] strap = 3'h0;
  mtr_byte_t  m [0:4] = '{default: 8'h00};
  logic [5:0] st = 6'h00;
  logic       scl;
  logic       hsda;
  logic       sda_oe_n;
  logic       sda_out;
  logic       sample_ready;
  wire logic  sda_w = hsda & (sda_oe_n | sda_out);
  int         mismatches = 0;
  int         checked = 0;
  int         cyc = 0;
  mtr_byte_t  ptr = 8'h00;
  always #4 mclk = ~mclk;
  mtr_target #(.START_CYCLES(200), .UPDATE_CYCLES(100)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_strap(strap), .holdup_cap_voltage(m[0]), .output_current(m[1]), .feed_a_voltage(m[2]),
    .feed_b_voltage(m[3]), .avg_temperature(m[4]), .feed_a_enable(st[0]), .feed_b_enable(st[1]),
    .primary_alarm(st[2]), .holdup_switch(st[3]), .hotswap_switch(st[4]), .vout_above_uv(st[5]),
    .sample_ready(sample_ready));
  mtr_i2c_host host (.mclk(mclk), .sda_wire(sda_w), .scl(scl), .sda(hsda));
  // ==========
  // expectations
  function automatic mtr_byte_t exp_reg(input mtr_byte_t i);
    case (i)
      `MTR_IDX_STATUS:  return {1'b0, st[5:3], 1'b0, st[2:0]};
      `MTR_IDX_HOLDUP:  return m[0];
      `MTR_IDX_CURRENT: return m[1];
      `MTR_IDX_FEED_A:  return m[2];
      `MTR_IDX_FEED_B:  return m[3];
      `MTR_IDX_TEMP:    return m[4];
      default:          return 8'h00;
    endcase
  endfunction
  function automatic mtr_byte_t nx(input mtr_byte_t p);
    return (p == `MTR_PTR_MAX) ? p : p + 8'h01;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ==========
  // bus transfers
  task automatic wr(input logic [2:0] a, input mtr_byte_t p, input int extra, input logic exp_ack);
    logic [7:0] r;
    logic       got;
    host.start;
    host.xfer({`MTR_ADDR_FIXED, a, 1'b0}, 1'b1, r, got);
    chk("write address ack", {7'h00, got}, {7'h00, exp_ack});
    host.xfer(p, 1'b1, r, got);
    chk("pointer byte ack", {7'h00, got}, {7'h00, exp_ack});
    repeat (extra) host.xfer(8'($urandom), 1'b1, r, got);
    host.stop;
    if (exp_ack) begin
      ptr = p;
      repeat (extra) ptr = nx(ptr);
    end
  endtask
  task automatic rd(input int n);
    logic [7:0] r;
    logic       got;
    host.start;
    host.xfer({`MTR_ADDR_FIXED, strap, 1'b1}, 1'b1, r, got);
    chk("read address ack", {7'h00, got}, 8'h01);
    for (int i = 1; i <= n; i++) begin
      host.xfer(8'hFF, i == n, r, got);
      chk("read byte", r, exp_reg(ptr));
      ptr = nx(ptr);
    end
    host.stop;
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    void'($urandom(98));
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("sample ready", {7'h00, sample_ready}, 8'h01);
    rd(2);
    @(posedge mclk);
    st <= 6'h3F;
    repeat (400) @(posedge mclk);
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      repeat (4) @(posedge mclk);
      wr(3'(s), 8'hF0 + 8'(s), 0, 1'b1);
      wr(3'(s + 1), `MTR_IDX_STATUS, 1, 1'b0);
      rd(1);
    end
    for (int k = 0; k < 3; k++) begin
      host.slow = k;
      @(posedge mclk);
      foreach (m[j]) m[j] <= 8'($urandom);
      st <= (k == 0) ? 6'h3F : 6'($urandom);
      repeat (400) @(posedge mclk);
      wr(strap, 8'h16 + 8'($urandom_range(0, 6)), $urandom_range(0, 2), 1'b1);
      rd(2);
      rd(18);
    end
    wr(strap, `MTR_PTR_MAX - 8'h01, 3, 1'b1);
    rd(3);
    results;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      results;
    end
  end
endmodule
bind mtr_target mtr_target_assertions u_chk (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap(addr_strap));
`default_nettype wire
